// ==== rtl/rsa_alu_core.sv ====
// Combinational operation core: rotates and subtract-with-borrow.
// Assumes the top registers every result and steers it to its target.
`timescale 1ns/10ps
`default_nettype none
module rsa_alu_core (
	rsa_alu_if.core alu
);
	import rsa_pkg::*;

	logic [RSA_DATA_W:0] sum9;
	logic [RSA_NIB_W:0] nib5;
	rsa_byte_t sub_opnd;
	rsa_byte_t diff;
	logic ov;
	logic zero;

	// Difference as acc + ~opnd + carry, so carry out is inverted borrow
	always_comb begin
		sub_opnd = (alu.op == RSA_SUB_WITH_BORROW_IMM) ? alu.imm : alu.mem;
		sum9 = {1'b0, alu.acc} + {1'b0, ~sub_opnd}
			+ {{RSA_DATA_W{1'b0}}, alu.carry};
		nib5 = {1'b0, alu.acc[RSA_NIB_W-1:0]} + {1'b0, ~sub_opnd[RSA_NIB_W-1:0]}
			+ {{RSA_NIB_W{1'b0}}, alu.carry};
		diff = sum9[RSA_DATA_W-1:0];
		ov = (alu.acc[RSA_DATA_W-1] != sub_opnd[RSA_DATA_W-1])
			&& (diff[RSA_DATA_W-1] != alu.acc[RSA_DATA_W-1]);
		zero = (diff == RSA_ZERO);
	end

	// Operation select; carry flag image is built only by ops that write carry
	always_comb begin
		alu.result = alu.mem;
		alu.wr_acc = 1'b0;
		alu.wr_mem = 1'b0;
		alu.wr_carry = 1'b0;
		alu.wr_all = 1'b0;
		alu.flags_new = '0;
		unique case (alu.op)
			RSA_ROTL_CARRY_TO_ACC: begin
				alu.result = {alu.mem[RSA_DATA_W-2:0], alu.carry};
				alu.flags_new[RSA_FB_C] = alu.mem[RSA_DATA_W-1];
				alu.wr_acc = 1'b1;
				alu.wr_carry = 1'b1;
			end
			RSA_ROTR_MEM: begin
				alu.result = {alu.mem[0], alu.mem[RSA_DATA_W-1:1]};
				alu.wr_mem = 1'b1;
			end
			RSA_ROTR_TO_ACC: begin
				alu.result = {alu.mem[0], alu.mem[RSA_DATA_W-1:1]};
				alu.wr_acc = 1'b1;
			end
			RSA_ROTR_CARRY_MEM: begin
				alu.result = {alu.carry, alu.mem[RSA_DATA_W-1:1]};
				alu.flags_new[RSA_FB_C] = alu.mem[0];
				alu.wr_mem = 1'b1;
				alu.wr_carry = 1'b1;
			end
			RSA_ROTR_CARRY_TO_ACC: begin
				alu.result = {alu.carry, alu.mem[RSA_DATA_W-1:1]};
				alu.flags_new[RSA_FB_C] = alu.mem[0];
				alu.wr_acc = 1'b1;
				alu.wr_carry = 1'b1;
			end
			RSA_SUB_WITH_BORROW, RSA_SUB_WITH_BORROW_IMM: begin
				alu.result = diff;
				alu.wr_acc = 1'b1;
				alu.wr_all = 1'b1;
				alu.flags_new[RSA_FB_C] = sum9[RSA_DATA_W];
				alu.flags_new[RSA_FB_AC] = nib5[RSA_NIB_W];
				alu.flags_new[RSA_FB_Z] = zero;
				alu.flags_new[RSA_FB_OV] = ov;
				alu.flags_new[RSA_FB_SC] = ov ^ diff[RSA_DATA_W-1];
				// Chained zero only holds if the earlier byte was zero too
				alu.flags_new[RSA_FB_CZ] = zero & alu.chained_zero;
			end
			default: begin
				alu.result = alu.mem; // Illegal code: no write at all
			end
		endcase
	end
endmodule : rsa_alu_core
`default_nettype wire

// ==== rtl/rsa_alu_if.sv ====
// Bundle between the datapath top and its combinational operation core.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface rsa_alu_if;
	import rsa_pkg::*;
	rsa_op_e op;
	rsa_byte_t acc;
	rsa_byte_t mem;
	rsa_byte_t imm;
	logic carry;
	logic chained_zero;
	rsa_byte_t result;
	logic wr_acc;
	logic wr_mem;
	logic wr_carry;
	logic wr_all;
	rsa_flags_t flags_new;

	modport core (input op, acc, mem, imm, carry, chained_zero,
		output result, wr_acc, wr_mem, wr_carry, wr_all, flags_new);
	modport user (output op, acc, mem, imm, carry, chained_zero,
		input result, wr_acc, wr_mem, wr_carry, wr_all, flags_new);
endinterface : rsa_alu_if
`default_nettype wire

// ==== rtl/rsa_pkg.sv ====
// Shared constants and types for the rotate/subtract datapath.
// Assumes an 8-bit core with a simple single-cycle register port.
package rsa_pkg;
	localparam int RSA_DATA_W = 8;
	localparam int RSA_ADDR_W = 4;
	localparam int RSA_NIB_W = 4;
	localparam int RSA_FLAG_W = 6;
	// Register byte addresses
	localparam logic [RSA_ADDR_W-1:0] RSA_OFS_ACC = 4'h0;
	localparam logic [RSA_ADDR_W-1:0] RSA_OFS_FLAGS = 4'h4;
	// Flag bit positions in the status register
	localparam int RSA_FB_C = 0;
	localparam int RSA_FB_AC = 1;
	localparam int RSA_FB_Z = 2;
	localparam int RSA_FB_OV = 3;
	localparam int RSA_FB_SC = 4;
	localparam int RSA_FB_CZ = 5;
	// Reset values
	localparam logic [RSA_DATA_W-1:0] RSA_ACC_RST = 8'h00;
	localparam logic [RSA_FLAG_W-1:0] RSA_FLAGS_RST = 6'h00;
	localparam logic [RSA_DATA_W-1:0] RSA_ZERO = 8'h00;

	typedef logic [RSA_DATA_W-1:0] rsa_byte_t;
	typedef logic [RSA_FLAG_W-1:0] rsa_flags_t;

	// Operation codes presented by the instruction sequencer
	typedef enum logic [2:0] {
		RSA_ROTL_CARRY_TO_ACC,
		RSA_ROTR_MEM,
		RSA_ROTR_TO_ACC,
		RSA_ROTR_CARRY_MEM,
		RSA_ROTR_CARRY_TO_ACC,
		RSA_SUB_WITH_BORROW,
		RSA_SUB_WITH_BORROW_IMM
	} rsa_op_e;
endpackage : rsa_pkg

// ==== rtl/rsa_top.sv ====
// Rotate and subtract-with-borrow datapath with accumulator and flags.
// Assumes the sequencer gives one op per strobe with its operand valid
// in the same cycle, and accepts a one-cycle memory write-back pulse.
//
// Summary of operation
// - Left rotate through carry into accumulator.
// - Right rotate memory in place, flags kept.
// - Right rotate memory into accumulator, flags kept.
// - Right rotate memory through carry, write back.
// - Right rotate through carry into accumulator.
// - Accumulator minus memory minus inverted carry.
// - Carry set when difference non-negative, else cleared.
// - Subtract updates six flags; rotates through carry update carry only.
// - Subtract variant uses immediate operand.
// - Immediate subtract result goes to accumulator.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rsa_top (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Sequencer side
	input wire logic i_op_valid,
	input wire rsa_pkg::rsa_op_e i_op,
	input wire rsa_pkg::rsa_byte_t i_mem_rdata,
	input wire rsa_pkg::rsa_byte_t i_imm,
	output logic o_mem_we,
	output rsa_pkg::rsa_byte_t o_mem_wdata,
	output logic o_op_done,
	output rsa_pkg::rsa_byte_t o_acc,
	output rsa_pkg::rsa_flags_t o_flags,
	// Register port
	input wire logic [rsa_pkg::RSA_ADDR_W-1:0] i_reg_addr,
	input wire rsa_pkg::rsa_byte_t i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output rsa_pkg::rsa_byte_t o_reg_rdata
);
	import rsa_pkg::*;

	rsa_byte_t accumulator_reg_q;
	rsa_byte_t accumulator_reg_d;
	rsa_flags_t flags_q;
	rsa_flags_t flags_d;
	logic mem_we_q;
	logic mem_we_d;
	rsa_byte_t mem_wdata_q;
	rsa_byte_t mem_wdata_d;
	logic op_done_q;
	logic op_done_d;
	rsa_byte_t rdata_q;
	rsa_byte_t rdata_d;

	rsa_alu_if alu ();

	// Core sees the registered accumulator and flags
	assign alu.op = i_op;
	assign alu.acc = accumulator_reg_q;
	assign alu.mem = i_mem_rdata;
	assign alu.imm = i_imm;
	assign alu.carry = flags_q[RSA_FB_C];
	assign alu.chained_zero = flags_q[RSA_FB_CZ];

	rsa_alu_core u_core (
		.alu(alu)
	);

	// Next state; an op beats a same-cycle register write so the
	// sequencer never loses a result to software
	always_comb begin
		accumulator_reg_d = accumulator_reg_q;
		flags_d = flags_q;
		mem_we_d = 1'b0;
		mem_wdata_d = mem_wdata_q;
		op_done_d = 1'b0;
		if (i_reg_wr && i_reg_addr == RSA_OFS_ACC) begin
			accumulator_reg_d = i_reg_wdata;
		end
		if (i_reg_wr && i_reg_addr == RSA_OFS_FLAGS) begin
			flags_d = i_reg_wdata[RSA_FLAG_W-1:0];
		end
		if (i_op_valid) begin
			op_done_d = 1'b1;
			if (alu.wr_acc) begin
				accumulator_reg_d = alu.result;
			end
			if (alu.wr_mem) begin
				mem_we_d = 1'b1;
				mem_wdata_d = alu.result;
			end
			if (alu.wr_all) begin
				flags_d = alu.flags_new;
			end else if (alu.wr_carry) begin
				flags_d[RSA_FB_C] = alu.flags_new[RSA_FB_C];
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_comb begin
		rdata_d = RSA_ZERO;
		if (i_reg_rd && i_reg_addr == RSA_OFS_ACC) begin
			rdata_d = accumulator_reg_q;
		end else if (i_reg_rd && i_reg_addr == RSA_OFS_FLAGS) begin
			rdata_d = {{(RSA_DATA_W-RSA_FLAG_W){1'b0}}, flags_q};
		end
	end

	// State registers
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			accumulator_reg_q <= RSA_ACC_RST;
			flags_q <= RSA_FLAGS_RST;
			mem_we_q <= 1'b0;
			mem_wdata_q <= RSA_ZERO;
			op_done_q <= 1'b0;
			rdata_q <= RSA_ZERO;
		end else begin
			accumulator_reg_q <= accumulator_reg_d;
			flags_q <= flags_d;
			mem_we_q <= mem_we_d;
			mem_wdata_q <= mem_wdata_d;
			op_done_q <= op_done_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_acc = accumulator_reg_q;
	assign o_flags = flags_q;
	assign o_mem_we = mem_we_q; // Pulse; address is the sequencer's own
	assign o_mem_wdata = mem_wdata_q;
	assign o_op_done = op_done_q;
	assign o_reg_rdata = rdata_q;
endmodule : rsa_top
`default_nettype wire

// ==== testbench/rotate_subtract_alu_ops_tb_top.sv ====
// Self-checking bench for the rotate/subtract datapath.
// Assumes every op answers exactly one cycle after its strobe.
`timescale 1ns/10ps
`default_nettype none
module rotate_subtract_alu_ops_tb_top;
	import rsa_pkg::*;
	logic clk = 0, rst = 1, v = 0, wr = 0, rd = 0, we, done, ec = 0;
	rsa_op_e op = RSA_ROTR_MEM;
	rsa_byte_t m = 0, x = 0, rwd = 0, wd, acc, rdat, mb, ea = 0, ew = 0;
	logic [RSA_ADDR_W-1:0] ad = 0;
	rsa_flags_t fl;
	rsa_flags_t ef = 0;
	int n_errors = 0, comparisons = 0;
	always #25 clk = ~clk;
	rsa_top rsa_top_inst (.i_sys_clk(clk), .i_sys_rst(rst), .i_op_valid(v),
		.i_op(op), .i_mem_rdata(m), .i_imm(x), .o_mem_we(we),
		.o_mem_wdata(wd), .o_op_done(done), .o_acc(acc), .o_flags(fl),
		.i_reg_addr(ad), .i_reg_wdata(rwd), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_reg_rdata(rdat));
	rsa_mem_model rsa_mem_model_inst (.i_sys_clk(clk), .i_we(we),
		.i_wdata(wd), .o_byte(mb));
	task automatic chk(input string n, input logic [8:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// Subtract flags from exact signed and unsigned arithmetic
	function automatic rsa_flags_t sbc_flags(rsa_byte_t a, s, logic c, cz);
		int u;
		int sd;
		int lo;
		rsa_flags_t f;
		u = int'(a) - int'(s) - int'(!c);
		sd = int'($signed(a)) - int'($signed(s)) - int'(!c);
		lo = int'(a[3:0]) - int'(s[3:0]) - int'(!c);
		f = '0;
		f[RSA_FB_C] = (u >= 0);
		f[RSA_FB_AC] = (lo >= 0);
		f[RSA_FB_Z] = (u[7:0] == 8'h00);
		f[RSA_FB_OV] = (sd < -128) || (sd > 127);
		f[RSA_FB_SC] = (sd < 0);
		f[RSA_FB_CZ] = f[RSA_FB_Z] && cz;
		return f;
	endfunction : sbc_flags
	// Expected {carry, acc, write-back} from the bench's own state
	function automatic logic [16:0] calc(rsa_op_e o, rsa_byte_t a, b);
		logic [8:0] d;
		d = {1'b0, ea} - {1'b0, b} - 9'(!ec);
		case (o)
		RSA_ROTL_CARRY_TO_ACC: return {a[7], a[6:0], ec, ew};
		RSA_ROTR_MEM: return {ec, ea, a[0], a[7:1]};
		RSA_ROTR_TO_ACC: return {ec, a[0], a[7:1], ew};
		RSA_ROTR_CARRY_MEM: return {a[0], ea, ec, a[7:1]};
		RSA_ROTR_CARRY_TO_ACC: return {a[0], ec, a[7:1], ew};
		RSA_SUB_WITH_BORROW, RSA_SUB_WITH_BORROW_IMM: return {!d[8], d[7:0], ew};
		default: return {ec, ea, ew};
		endcase
	endfunction : calc
	task automatic do_op(input rsa_op_e o, input rsa_byte_t a, b);
		logic [16:0] r;
		logic s;
		rsa_byte_t sb;
		rsa_flags_t f;
		sb = (o == RSA_SUB_WITH_BORROW_IMM) ? b : a;
		r = calc(o, a, sb);
		s = (o == RSA_SUB_WITH_BORROW || o == RSA_SUB_WITH_BORROW_IMM);
		// Rotates touch carry only; subtracts rebuild all six flags
		f = ef;
		f[RSA_FB_C] = r[16];
		if (s) f = sbc_flags(ea, sb, ec, ef[RSA_FB_CZ]);
		@(posedge clk);
		v <= 1;
		op <= o;
		m <= a;
		x <= b;
		@(posedge clk);
		v <= 0;
		#1;
		chk("done", done, 1);
		chk("acc", acc, r[15:8]);
		chk("carry", fl[0], r[16]);
		chk("wdata", wd, r[7:0]);
		chk("we", we, o == RSA_ROTR_MEM || o == RSA_ROTR_CARRY_MEM);
		if (s) chk("zero", fl[2], r[15:8] == 8'h00);
		chk("flags", fl, f);
		{ec, ea, ew} = r;
		ef = f;
	endtask : do_op
	// One register strobe; read data stands in the following cycle
	task automatic rio(input logic w, input logic [3:0] a, input rsa_byte_t d);
		@(posedge clk);
		ad <= a;
		rwd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		#1;
	endtask : rio
	task automatic give_verdict;
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		#1ms;
		n_errors++;
		give_verdict;
	end
	initial begin
		m <= 8'($urandom(32'h5345));
		repeat (6) @(posedge clk);
		rst <= 0;
		#1;
		chk("rst acc", acc, 0);
		chk("rst flags", fl, 0);
		rio(1, RSA_OFS_ACC, 8'h10);
		rio(1, RSA_OFS_FLAGS, 8'h21);
		rio(0, RSA_OFS_FLAGS, 8'h00);
		chk("flags rd", rdat, 8'h21);
		rio(0, RSA_OFS_ACC, 8'h00);
		chk("acc rd", rdat, 8'h10);
		rio(0, 4'h8, 8'h00);
		chk("unmapped", rdat, 0);
		{ea, ec} = {8'h10, 1'b1};
		ef = 6'h21;
		// Zero result with chained zero set keeps the chain alive
		do_op(RSA_SUB_WITH_BORROW, 8'h10, 8'h00);
		do_op(RSA_SUB_WITH_BORROW, 8'h20, 8'h00);
		do_op(RSA_SUB_WITH_BORROW_IMM, 8'h00, 8'hef);
		do_op(RSA_SUB_WITH_BORROW_IMM, 8'h00, 8'h7f);
		do_op(RSA_ROTR_CARRY_MEM, 8'h81, 8'h00);
		for (int i = 0; i < 80; i++)
			do_op(rsa_op_e'(3'($urandom)), 8'($urandom), 8'($urandom));
		@(posedge clk);
		#1;
		chk("mem byte", mb, ew);
		give_verdict;
	end
endmodule : rotate_subtract_alu_ops_tb_top
`default_nettype wire

// ==== testbench/rsa_mem_model.sv ====
// Data memory byte that takes the datapath's write-backs.
// Assumes one location; the sequencer holds its address.
`timescale 1ns/10ps
`default_nettype none
module rsa_mem_model (
	input wire logic i_sys_clk,
	input wire logic i_we,
	input wire rsa_pkg::rsa_byte_t i_wdata,
	output var rsa_pkg::rsa_byte_t o_byte
);
	// Stores only on the pulse, so stale data shows a missed pulse
	always @(posedge i_sys_clk) begin
		if (i_we) begin
			o_byte <= i_wdata;
		end
	end
endmodule : rsa_mem_model
`default_nettype wire

// ==== testbench/rsa_monitor.sv ====
// Checker for the rotate/subtract datapath, top ports only.
// Assumes it is bound into every rsa_top instance.
`timescale 1ns/10ps
`default_nettype none
module rsa_monitor
	import rsa_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_op_valid,
	input wire rsa_pkg::rsa_op_e i_op,
	input wire rsa_pkg::rsa_byte_t i_mem_rdata,
	input wire rsa_pkg::rsa_byte_t i_imm,
	input wire logic i_reg_wr,
	input wire logic o_mem_we,
	input wire rsa_pkg::rsa_byte_t o_mem_wdata,
	input wire logic o_op_done,
	input wire rsa_pkg::rsa_byte_t o_acc,
	input wire rsa_pkg::rsa_flags_t o_flags
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// Register writes in the op cycle may merge into flags, so skip them
	wire logic v = i_op_valid && !i_reg_wr;
	wire rsa_byte_t m = i_mem_rdata;
	wire logic c = o_flags[0];
	wire logic [8:0] sm = {1'b0, o_acc} - {1'b0, m} - 9'(!c);
	wire logic [8:0] si = {1'b0, o_acc} - {1'b0, i_imm} - 9'(!c);
	rotl_acc_a: assert property (v && i_op == RSA_ROTL_CARRY_TO_ACC
		|=> o_acc == {$past(m[6:0]), $past(c)} && o_flags ==
		{$past(o_flags[5:1]), $past(m[7])}) else $error("rotl bad");
	rotr_mem_a: assert property (v && i_op == RSA_ROTR_MEM |=>
		o_mem_we && o_mem_wdata == {$past(m[0]), $past(m[7:1])}
		&& $stable(o_flags)) else $error("rotr mem bad");
	rotr_acc_a: assert property (v && i_op == RSA_ROTR_TO_ACC |=>
		o_acc == {$past(m[0]), $past(m[7:1])} && $stable(o_flags)
		&& !o_mem_we) else $error("rotr acc bad");
	rrc_mem_a: assert property (v && i_op == RSA_ROTR_CARRY_MEM |=>
		o_mem_wdata == {$past(c), $past(m[7:1])} && o_flags ==
		{$past(o_flags[5:1]), $past(m[0])}) else $error("rrc mem bad");
	rrc_acc_a: assert property (v && i_op == RSA_ROTR_CARRY_TO_ACC
		|=> o_acc == {$past(c), $past(m[7:1])} && c == $past(m[0])
		&& !o_mem_we) else $error("rrc acc bad");
	sbc_acc_a: assert property (v && i_op == RSA_SUB_WITH_BORROW |=>
		o_acc == $past(sm[7:0]) && !o_mem_we) else $error("sbc acc bad");
	sbc_carry_a: assert property (v && i_op == RSA_SUB_WITH_BORROW
		|=> c == !$past(sm[8])) else $error("sbc carry bad");
	sbc_imm_a: assert property (v && i_op == RSA_SUB_WITH_BORROW_IMM
		|=> o_acc == $past(si[7:0]) && c == !$past(si[8]))
		else $error("sbc imm bad");
	sbc_zero_a: assert property (v && (i_op == RSA_SUB_WITH_BORROW
		|| i_op == RSA_SUB_WITH_BORROW_IMM)
		|=> o_flags[2] == (o_acc == 8'h00)) else $error("sbc zero bad");
	sbc_chain_a: assert property (v && i_op == RSA_SUB_WITH_BORROW
		|=> o_flags[5] == (o_flags[2] && $past(o_flags[5])))
		else $error("sbc chain bad");
endmodule : rsa_monitor
bind rsa_top rsa_monitor rsa_monitor_inst (.i_sys_clk, .i_sys_rst,
	.i_op_valid, .i_op, .i_mem_rdata, .i_imm, .i_reg_wr, .o_mem_we,
	.o_mem_wdata, .o_op_done, .o_acc, .o_flags);
`default_nettype wire
